// >>> sfs_regs.vh
// Register map, field positions and reset values for the frame sync control block.
// Included by the frame sync modules; defines only, no logic.
`ifndef SFS_REGS_VH
`define SFS_REGS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SFS_CTRL_OFFSET    12'h000
`define SFS_STATUS_OFFSET  12'h004

// ****************************************
// Control register fields
// ****************************************
`define SFS_FRAME_EN_BIT   15
`define SFS_DIR_BIT        14
`define SFS_POL_BIT        13
`define SFS_EDGE_BIT       1
`define SFS_CTRL_RESET     16'h0000
`define SFS_CTRL_WMASK     16'hE002

// ****************************************
// Status register fields
// ****************************************
`define SFS_ST_BUSY_BIT    0
`define SFS_ST_PIN_BIT     1
`define SFS_ST_SEEN_BIT    2
`define SFS_ST_CNT_LSB     8
`define SFS_ST_CNT_MSB     15

`endif

// >>> sfs_sync2.v
// Two-stage synchroniser for a group of asynchronous inputs.
// Assumes the inputs are quasi-static or sampled repeatedly by the reader.
`timescale 1ns/1ps

module sfs_sync2
#(
  parameter             WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
)
(
  input  wire             clk,    // Sampling clock
  input  wire             rst_n,  // Asynchronous reset, active low
  input  wire [WIDTH-1:0] d,      // Asynchronous inputs
  output wire [WIDTH-1:0] q       // Synchronised outputs
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // Reset to each pin's idle level, so no false edge follows reset
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule // sfs_sync2

// >>> sfs_master_gen.v
// Frame sync pulse generator for the master direction.
// Assumes sclk_rise is a one-cycle pulse on each rising edge of the bit clock.
`timescale 1ns/1ps

module sfs_master_gen
(
  input  wire pclk,       // System clock
  input  wire presetn,    // Asynchronous reset, active low
  input  wire start,      // Request a new frame
  input  wire enable,     // Framed master mode active
  input  wire edge_sel,   // 1: sync with first bit, 0: one bit before
  input  wire sclk_rise,  // Bit clock rising edge pulse
  output reg  sync_ff,    // Frame sync active (logical level)
  output reg  first_ff,   // First bit clock pulse
  output wire busy        // Frame sequence in progress
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_WAIT  = 2'h1;
  localparam [1:0] ST_LEAD  = 2'h2;
  localparam [1:0] ST_PULSE = 2'h3;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg       edge_ff;
  reg       nxt_sync;
  reg       nxt_first;

  always @*
  begin
    nxt_state = state_ff;
    nxt_sync  = sync_ff;
    nxt_first = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (start && enable)
          nxt_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (sclk_rise)
        begin
          nxt_sync = 1'b1;
          if (edge_ff)
          begin
            nxt_first = 1'b1;
            nxt_state = ST_PULSE;
          end
          else
            nxt_state = ST_LEAD;
        end
      end
      ST_LEAD:
      begin
        if (sclk_rise)
        begin
          nxt_first = 1'b1;
          nxt_sync  = 1'b0;
          nxt_state = ST_IDLE;
        end
      end
      ST_PULSE:
      begin
        if (sclk_rise)
        begin
          nxt_sync  = 1'b0;
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_sync  = 1'b0;
      end
    endcase
    // Dropping the mode aborts the frame at once
    if (!enable)
    begin
      nxt_state = ST_IDLE;
      nxt_sync  = 1'b0;
      nxt_first = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_IDLE;
      sync_ff  <= 1'b0;
      first_ff <= 1'b0;
      edge_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      sync_ff  <= nxt_sync;
      first_ff <= nxt_first;
      // Timing choice frozen per frame
      if (state_ff == ST_IDLE)
        edge_ff <= edge_sel;
    end
  end

  assign busy = (state_ff != ST_IDLE);

endmodule // sfs_master_gen

// >>> sfs_frame_sync.v
// Frame sync control for a serial port: APB control and status registers, slave-select pin steering,
// frame sync generation (master) and detection (slave).
// Assumes the bit clock arrives asynchronously and is much slower than pclk.
`timescale 1ns/1ps
`include "sfs_regs.vh"

// Function
// - bit 15 turns slave select into sync
// - bit 14 set receives, clear generates
// - bit 13 sets sync active level
// - bit 1 coincident, else one bit early
// - other bits read zero, writes ignored
module sfs_frame_sync
#(
  parameter ADDR_W = 12
)
(
  input  wire              pclk,              // System clock, 250 MHz
  input  wire              presetn,           // Asynchronous reset, active low
  input  wire              psel,              // APB select
  input  wire              penable,           // APB enable
  input  wire              pwrite,            // APB direction, 1 = write
  input  wire [ADDR_W-1:0] paddr,             // APB byte address
  input  wire [31:0]       pwdata,            // APB write data
  output reg  [31:0]       prdata,            // APB read data
  output wire              pready,            // APB ready
  output wire              pslverr,           // APB error, unmapped address
  input  wire              sclk_pin,          // Serial bit clock pin
  input  wire              slave_select_pin_i, // Slave select pin level in
  output reg               slave_select_pin_o, // Slave select pin level out
  output reg               slave_select_pin_oe_n, // Pin drive enable, active low
  input  wire              ss_ord_o,          // Ordinary select level from engine
  input  wire              ss_ord_oe_n,       // Ordinary select drive, active low
  output reg               ss_ord_i,          // Ordinary select level to engine
  input  wire              frame_start,       // Engine asks for a master frame
  output reg               first_bit,         // First bit clock of a frame
  output wire              frame_mode,        // Framed operation enabled
  output wire              frame_busy         // Frame sequence in progress
);

  // ****************************************
  // Control register
  // ****************************************
  reg  [15:0] ctrl_ff;
  wire        wr_en;
  wire        rd_setup;
  wire        hit_ctrl;
  wire        hit_status;
  wire        en_bit;
  wire        dir_bit;
  wire        pol_bit;
  wire        edge_bit;

  assign hit_ctrl   = (paddr == `SFS_CTRL_OFFSET);
  assign hit_status = (paddr == `SFS_STATUS_OFFSET);
  assign wr_en      = psel && penable && pwrite && hit_ctrl;
  assign rd_setup   = psel && !penable && !pwrite;

  // Zero wait states; error only for addresses outside the map
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_ctrl && !hit_status;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= `SFS_CTRL_RESET;
    // only the four fields are stored
    else if (wr_en)
      ctrl_ff <= pwdata[15:0] & `SFS_CTRL_WMASK;
  end

  assign en_bit   = ctrl_ff[`SFS_FRAME_EN_BIT];
  assign dir_bit  = ctrl_ff[`SFS_DIR_BIT];
  assign pol_bit  = ctrl_ff[`SFS_POL_BIT];
  assign edge_bit = ctrl_ff[`SFS_EDGE_BIT];
  assign frame_mode = en_bit;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [1:0] pin_sync;
  wire       sclk_s;
  wire       ss_s;
  reg        sclk_d_ff;
  wire       sclk_rise;

  // Select idles high, so it resets to one
  sfs_sync2
  #(
    .WIDTH   (2),
    .RST_VAL (2'b10)
  )
  u_sync
  (
    .clk     (pclk),
    .rst_n   (presetn),
    .d       ({slave_select_pin_i, sclk_pin}),
    .q       (pin_sync)
  );

  assign sclk_s = pin_sync[0];
  assign ss_s   = pin_sync[1];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sclk_d_ff <= 1'b0;
    else
      sclk_d_ff <= sclk_s;
  end

  assign sclk_rise = sclk_s && !sclk_d_ff;

  // ****************************************
  // Master direction
  // ****************************************
  wire master_en;
  wire m_sync;
  wire m_first;
  wire m_busy;

  assign master_en = en_bit && !dir_bit;

  // device generates the pulse as master
  sfs_master_gen u_master
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (frame_start),
    .enable    (master_en),
    .edge_sel  (edge_bit),
    .sclk_rise (sclk_rise),
    .sync_ff   (m_sync),
    .first_ff  (m_first),
    .busy      (m_busy)
  );

  // ****************************************
  // Slave direction
  // ****************************************
  wire slave_en;
  wire ss_active;
  reg  prev_act_ff;
  reg  pend_ff;
  reg  s_first_ff;
  reg  nxt_pend;
  reg  nxt_s_first;

  assign slave_en = en_bit && dir_bit;

  // level equal to polarity bit means active
  assign ss_active = (ss_s == pol_bit);

  always @*
  begin
    nxt_pend    = pend_ff;
    nxt_s_first = 1'b0;
    if (sclk_rise)
    begin
      if (pend_ff)
      begin
        nxt_s_first = 1'b1;
        nxt_pend    = 1'b0;
      end
      // new pulse seen at a bit clock edge
      else if (ss_active && !prev_act_ff)
      begin
        if (edge_bit)
          nxt_s_first = 1'b1;
        else
          nxt_pend = 1'b1;
      end
    end
    if (!slave_en)
    begin
      nxt_pend    = 1'b0;
      nxt_s_first = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_act_ff <= 1'b0;
      pend_ff     <= 1'b0;
      s_first_ff  <= 1'b0;
    end
    else
    begin
      // Sampled only on bit clock edges, like the partner drives it
      if (sclk_rise)
        prev_act_ff <= ss_active && slave_en;
      else if (!slave_en)
        prev_act_ff <= 1'b0;
      pend_ff    <= nxt_pend;
      s_first_ff <= nxt_s_first;
    end
  end

  // ****************************************
  // Pin steering and engine outputs
  // ****************************************
  reg nxt_pin_o;
  reg nxt_pin_oe_n;
  reg nxt_ord_i;

  always @*
  begin
    // ordinary select function when framing is off
    nxt_pin_o    = ss_ord_o;
    nxt_pin_oe_n = ss_ord_oe_n;
    nxt_ord_i    = ss_s;
    if (en_bit)
    begin
      nxt_ord_i = 1'b1;
      if (dir_bit)
      begin
        nxt_pin_o    = 1'b0;
        nxt_pin_oe_n = 1'b1;
      end
      else
      begin
        nxt_pin_o    = pol_bit ? m_sync : !m_sync;
        nxt_pin_oe_n = 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slave_select_pin_o    <= 1'b1;
      slave_select_pin_oe_n <= 1'b1;
      ss_ord_i              <= 1'b1;
      first_bit             <= 1'b0;
    end
    else
    begin
      slave_select_pin_o    <= nxt_pin_o;
      slave_select_pin_oe_n <= nxt_pin_oe_n;
      ss_ord_i              <= nxt_ord_i;
      first_bit             <= (m_first && master_en) || s_first_ff;
    end
  end

  assign frame_busy = m_busy || pend_ff;

  // ****************************************
  // Status: sticky seen flag and frame count
  // ****************************************
  reg       seen_ff;
  reg [7:0] cnt_ff;
  wire      clr_seen;

  // Writing one to the seen bit clears it; a new frame wins
  assign clr_seen = psel && penable && pwrite && hit_status && pwdata[`SFS_ST_SEEN_BIT];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seen_ff <= 1'b0;
      cnt_ff  <= 8'h00;
    end
    else
    begin
      if (first_bit)
      begin
        seen_ff <= 1'b1;
        cnt_ff  <= cnt_ff + 8'h01;
      end
      else if (clr_seen)
        seen_ff <= 1'b0;
    end
  end

  // ****************************************
  // Read data, captured in the setup cycle
  // ****************************************
  reg [31:0] nxt_rdata;

  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    // unimplemented bits come back as zero
    if (hit_ctrl)
      nxt_rdata[15:0] = ctrl_ff & `SFS_CTRL_WMASK;
    else if (hit_status)
    begin
      nxt_rdata[`SFS_ST_BUSY_BIT] = frame_busy;
      nxt_rdata[`SFS_ST_PIN_BIT]  = ss_s;
      nxt_rdata[`SFS_ST_SEEN_BIT] = seen_ff;
      nxt_rdata[`SFS_ST_CNT_MSB:`SFS_ST_CNT_LSB] = cnt_ff;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= nxt_rdata;
  end

endmodule // sfs_frame_sync

// >>> sfs_fs_props.sv
// Assertions on the ports of the frame sync control block.
// Assumes one pclk domain; bound to the top module below.
`timescale 1ns/1ps
`include "sfs_regs.vh"

module sfs_fs_props
#(
  parameter ADDR_W = 12
)
(
  input wire              pclk,                  // Clock
  input wire              presetn,               // Reset
  input wire              psel,                  // Select
  input wire              penable,               // Enable
  input wire              pwrite,                // Write
  input wire [ADDR_W-1:0] paddr,                 // Address
  input wire [31:0]       pwdata,                // Wdata
  input wire [31:0]       prdata,                // Rdata
  input wire              slave_select_pin_o,    // Pin level
  input wire              slave_select_pin_oe_n, // Pin drive
  input wire              ss_ord_o,              // Ord level
  input wire              ss_ord_oe_n,           // Ord drive
  input wire              ss_ord_i,              // Ord in
  input wire              first_bit,             // First bit
  input wire              frame_mode,            // Mode
  input wire              frame_busy             // Busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****
  // Shadow of the control fields
  // ****
  reg  dir_ff, pol_ff, edg_ff;
  wire acc    = psel && penable && paddr == `SFS_CTRL_OFFSET;
  wire wr_ctl = acc && pwrite;
  wire rd_ctl = acc && !pwrite;
  wire en_bit = pwdata[15];
  wire master = frame_mode && !dir_ff;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      {dir_ff, pol_ff, edg_ff} <= 3'b000;
    else if (wr_ctl)
      {dir_ff, pol_ff, edg_ff} <= {pwdata[14:13], pwdata[1]};

  // Idle master must hold several cycles; pin flop lags control
  sequence s_idle;
    (master && !frame_busy && $stable(pol_ff))[*4];
  endsequence
  sequence s_off2;
    !frame_mode ##1 !frame_mode;
  endsequence

  a_mode_load: assert property (wr_ctl |=> frame_mode == $past(en_bit))
    else $error("mode bit not loaded");
  a_read_mask: assert property (rd_ctl |->
    prdata == {16'h0000, frame_mode, dir_ff, pol_ff, 11'h000, edg_ff, 1'b0})
    else $error("control read wrong");
  a_off_follow: assert property (s_off2 ##0 $past(presetn) |-> slave_select_pin_o == $past(ss_ord_o) &&
    slave_select_pin_oe_n == $past(ss_ord_oe_n))
    else $error("pin not ordinary select");
  a_on_hold: assert property (frame_mode[*3] |-> ss_ord_i)
    else $error("select seen in framed mode");
  a_slave_float: assert property ((frame_mode && dir_ff)[*3] |-> slave_select_pin_oe_n)
    else $error("receiver drives pin");
  a_idle_level: assert property (s_idle |-> !slave_select_pin_oe_n && slave_select_pin_o == !pol_ff)
    else $error("idle sync level wrong");
  a_sync_with: assert property (first_bit && master && edg_ff |-> ##[0:4] slave_select_pin_o == pol_ff)
    else $error("sync not with first bit");
  a_sync_early: assert property (first_bit && master && !edg_ff |-> $past(slave_select_pin_o, 20) == pol_ff)
    else $error("sync not one bit early");
  a_no_early: assert property (first_bit && master && edg_ff |-> $past(slave_select_pin_o, 20) != pol_ff)
    else $error("sync came too early");
endmodule // sfs_fs_props

bind sfs_frame_sync sfs_fs_props #(.ADDR_W(ADDR_W)) u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .slave_select_pin_o, .slave_select_pin_oe_n, .ss_ord_o, .ss_ord_oe_n,
  .ss_ord_i, .first_bit, .frame_mode, .frame_busy);

// >>> sfs_peer.sv
// Far-side serial partner: bit clock and received frame sync.
// Assumes the bit clock stands still between frames.
`timescale 1ns/1ps

module sfs_peer
(
  output logic sclk, // Bit clock
  output logic lvl   // Sync line level
);
  int nrise = 0;
  initial
  begin
    sclk = 0;
    lvl = 0;
  end

  // ****
  // One frame of four bit clocks
  // ****
  task automatic frame(input logic drv, input logic pol);
    int k;
    // Line moves only well away from pclk edges
    #37;
    for (k = 1; k <= 4; k++)
    begin
      if (drv) lvl = (k == 2) ? pol : !pol;
      #80 sclk = 1;
      nrise = k;
      #80 sclk = 0;
    end
    // Released line is not kind: inverse of last
    lvl = !lvl;
  endtask
endmodule // sfs_peer

// >>> sfs_tb.sv
// Self-checking bench for the frame sync control block.
// Assumes the peer supplies bit clock and received sync.
`timescale 1ns/1ps
`include "sfs_regs.vh"

module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic        ss_ord_o = 1, ss_ord_oe_n = 1, frame_start = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, sclk, peer_lvl, pin_o, pin_oe_n, ss_ord_i, first_bit, frame_mode, frame_busy;
  wire         pin_line = pin_oe_n ? peer_lvl : pin_o;
  int          num_errors = 0, total_checks = 0;

  sfs_frame_sync DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sclk_pin(sclk), .slave_select_pin_i(pin_line), .slave_select_pin_o(pin_o),
    .slave_select_pin_oe_n(pin_oe_n), .ss_ord_o, .ss_ord_oe_n, .ss_ord_i, .frame_start,
    .first_bit, .frame_mode, .frame_busy);
  sfs_peer peer (.sclk, .lvl(peer_lvl));
  always #2 pclk = ~pclk;

  // ****
  // Shared tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic sig(input int w);
    return w == 0 ? pready : w == 1 ? first_bit : frame_busy;
  endfunction

  task automatic wait_for(input int w, input logic lvl);
    int n;
    for (n = 0; sig(w) !== lvl; n++)
    begin
      if (n == 500)
      begin
        num_errors++;
        complete_run();
      end
      @(posedge pclk);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    wait_for(0, 1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    apb(0, `SFS_CTRL_OFFSET, 32'h0000_0000);
    chk("ctrl reset", rd, {16'h0000, `SFS_CTRL_RESET});
    apb(1, `SFS_CTRL_OFFSET, 32'hFFFF_FFFF);
    apb(0, `SFS_CTRL_OFFSET, 32'h0000_0000);
    chk("ctrl mask", rd, 32'h0000_E002);
    chk("mode on", frame_mode, 1);
    apb(1, `SFS_CTRL_OFFSET, 32'hFFFF_1FFD);
    apb(0, `SFS_CTRL_OFFSET, 32'h0000_0000);
    chk("ctrl clear", rd, 0);
    chk("mode off", frame_mode, 0);
    apb(0, 12'h008, 32'h0000_0000);
    chk("unmapped err", er, 1);
    chk("unmapped data", rd, 0);
  endtask

  task automatic t_off(input logic v);
    ss_ord_oe_n <= 0;
    ss_ord_o <= v;
    repeat (6) @(posedge pclk);
    chk("pin level", pin_o, v);
    chk("pin drive", pin_oe_n, 0);
    chk("ord in", ss_ord_i, v);
    ss_ord_oe_n <= 1;
    repeat (2) @(posedge pclk);
    chk("pin release", pin_oe_n, 1);
  endtask

  task automatic t_master(input logic pol, edg);
    apb(1, `SFS_CTRL_OFFSET, {16'h0000, 2'b10, pol, 11'h000, edg, 1'b0});
    repeat (3) @(posedge pclk);
    chk("idle level", pin_o, !pol);
    chk("master drive", pin_oe_n, 0);
    chk("ord held", ss_ord_i, 1);
    frame_start <= 1;
    @(posedge pclk);
    frame_start <= 0;
    fork
      peer.frame(0, pol);
      begin
        wait_for(1, 1);
        chk("master rise", peer.nrise, edg ? 1 : 2);
        repeat (10) @(posedge pclk);
        chk("mid level", pin_o, edg ? pol : !pol);
      end
    join
    @(posedge pclk);
    wait_for(2, 0);
  endtask

  task automatic t_slave(input logic pol, edg);
    apb(1, `SFS_CTRL_OFFSET, {16'h0000, 2'b11, pol, 11'h000, edg, 1'b0});
    fork
      peer.frame(1, pol);
      begin
        wait_for(1, 1);
        chk("slave rise", peer.nrise, edg ? 2 : 3);
        chk("slave float", pin_oe_n, 1);
      end
    join
    @(posedge pclk);
    wait_for(2, 0);
  endtask

  // Eight frames seen, line left high by the partner
  task automatic t_status;
    repeat (4) @(posedge pclk);
    apb(0, `SFS_STATUS_OFFSET, 32'h0000_0000);
    chk("status count", rd, 32'h0000_0806);
    apb(1, `SFS_STATUS_OFFSET, 32'h0000_0004);
    apb(0, `SFS_STATUS_OFFSET, 32'h0000_0000);
    chk("seen clear", rd, 32'h0000_0802);
  endtask

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("reset mode", frame_mode, 0);
    t_regs();
    t_off(0);
    t_off(1);
    for (int i = 0; i < 4; i++)
      t_master(i[1], i[0]);
    for (int i = 0; i < 4; i++)
      t_slave(i[1], i[0]);
    t_status();
    complete_run();
  end
endmodule // tb
